/* module_power_sleep_control_defs.vh */
// Purpose: shared constants of the power, reset and sleep control block
// Assumes: 50 MHz system clock, millisecond tick as the slow time base
// Notes:   times are kept in their own unit; tick counts derive from them
`ifndef MODULE_POWER_SLEEP_CONTROL_DEFS_VH
`define MODULE_POWER_SLEEP_CONTROL_DEFS_VH

// clock and time base
`define CLK_MHZ              50
`define TICK_US              1000
`define TICK_CYCLES          (`CLK_MHZ * `TICK_US)
`define TICK_CNT_W           16

// input glitch filter, set in nanoseconds and used in system clock cycles
`define FILTER_NS            320
`define FILTER_CYCLES        ((`FILTER_NS * `CLK_MHZ + 999) / 1000)

// times in milliseconds
`define POWER_ON_HOLD_MS     1000
`define POWER_OFF_HOLD_MS    4000
`define KEY_TO_DPLUS_MS      7000
`define OFF_TO_DPLUS_LOW_MS  4000
`define RESET_MAX_LOW_MS     1000
`define WAKE_HOLD_MS         1000
`define HOST_WAKE_MS         1000
`define LAMP_PERIOD_MS       2000
`define LAMP_STEP_MS         100

// derived tick counts
`define MS_TICKS(ms)         (((ms) * 1000) / `TICK_US)
`define MS_CNT_W             13

// power states
`define PWR_OFF              2'h0
`define PWR_BOOT             2'h1
`define PWR_RUN              2'h2
`define PWR_HALT             2'h3

// network status codes for the lamp
`define NET_NO_SERVICE       2'h0
`define NET_REGISTERED       2'h1
`define NET_DIALUP           2'h2

`endif

/* input_filter.v */
// Purpose: two-flop synchroniser followed by a stability filter
// Assumes: input is asynchronous to clock
// Notes:   output changes only after FILTER_LEN equal synchronised samples
`timescale 1ns/10ps
`default_nettype none
module input_filter #(
  parameter       FILTER_LEN = 16,
  parameter [0:0] IDLE_LEVEL = 1'b1
) (
  // clock and reset
  input  wire clock,
  input  wire rst_n,
  // pin and filtered level
  input  wire pin_in,
  output reg  level
);

  reg       sync_a;
  reg       sync_b;
  reg [7:0] stable_cnt;

  // sync_a is read by sync_b only
  always @(posedge clock) begin
    if (!rst_n) begin
      sync_a     <= IDLE_LEVEL;
      sync_b     <= IDLE_LEVEL;
      stable_cnt <= 8'h00;
      level      <= IDLE_LEVEL;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      if (sync_b == level) begin
        stable_cnt <= 8'h00;
      end else if (stable_cnt == FILTER_LEN[7:0] - 8'h01) begin
        stable_cnt <= 8'h00;
        level      <= sync_b;
      end else begin
        stable_cnt <= stable_cnt + 8'h01;
      end
    end
  end

endmodule // input_filter
`default_nettype wire

/* module_power_sleep_control.v */
// Purpose: power key, hardware reset, sleep, host wake and status lamp logic
// Assumes: pins are asynchronous; sleep and wake requests come from core logic
// Notes:   all hold and pulse timing runs from a millisecond tick enable
`timescale 1ns/10ps
`default_nettype none
`include "module_power_sleep_control_defs.vh"

// Operation
// - key low at least 1 s while off starts power-on boot.
// - key low at least 4 s while on performs power-off.
// - D+ rises about 7 s after a valid power-on request.
// - D+ falls as soon as a power-off request is valid; power stays on 4 s more.
// - reset low pulse resets hardware, restarts boot, emits startup report.
// - reset held low over 1 s powers the module off instead.
// - sleep inhibit reads low when floating; low permits sleep.
// - sleep inhibit high prevents entering sleep.
// - sleep inhibit high for 1 s wakes a sleeping module.
// - awake output high when awake, low when sleeping.
// - host wake output signals the host to wake up.
// - host wake pulse is 1 s high, then idle low.
// - no service lamp: low 0.1, high 0.1, low 0.1, high 1.7 s.
// - registered lamp: low 0.1 s, high 1.9 s.
// - dial-up connected lamp held continuously low.
module module_power_sleep_control #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // host control pins
  input  wire       power_key_n,
  input  wire       hw_reset_n,
  input  wire       sleep_inhibit,
  // core logic requests
  input  wire       sleep_request,
  input  wire       host_wake_request,
  input  wire [1:0] net_status,
  // power and link state
  output reg        power_on,
  output reg        core_reset,
  output reg        usb_dplus,
  output reg        startup_report,
  // sleep and indicators
  output reg        awake,
  output reg        host_wake_out,
  output reg        status_lamp_out
);

  // integer counts first, then cut to the counter widths on purpose
  localparam integer ON_HOLD_TICKS    = `MS_TICKS(`POWER_ON_HOLD_MS);
  localparam integer OFF_HOLD_TICKS   = `MS_TICKS(`POWER_OFF_HOLD_MS);
  localparam integer BOOT_TICKS       = `MS_TICKS(`KEY_TO_DPLUS_MS);
  localparam integer HALT_TICKS       = `MS_TICKS(`OFF_TO_DPLUS_LOW_MS);
  localparam integer RESET_MAX_TICKS  = `MS_TICKS(`RESET_MAX_LOW_MS);
  localparam integer WAKE_HOLD_TICKS  = `MS_TICKS(`WAKE_HOLD_MS);
  localparam integer HWAKE_TICKS      = `MS_TICKS(`HOST_WAKE_MS);
  localparam integer LAMP_LAST_TICKS  = `MS_TICKS(`LAMP_PERIOD_MS) - 1;
  localparam integer STEP_TICKS       = `MS_TICKS(`LAMP_STEP_MS);
  localparam integer TICK_LAST_CYCLES = TICK_CYCLES - 1;

  localparam [`MS_CNT_W-1:0] ON_HOLD    = ON_HOLD_TICKS[`MS_CNT_W-1:0];
  localparam [`MS_CNT_W-1:0] OFF_HOLD   = OFF_HOLD_TICKS[`MS_CNT_W-1:0];
  localparam [`MS_CNT_W-1:0] BOOT_TIME  = BOOT_TICKS[`MS_CNT_W-1:0];
  localparam [`MS_CNT_W-1:0] HALT_TIME  = HALT_TICKS[`MS_CNT_W-1:0];
  localparam [`MS_CNT_W-1:0] RESET_MAX  = RESET_MAX_TICKS[`MS_CNT_W-1:0];
  localparam [`MS_CNT_W-1:0] WAKE_HOLD  = WAKE_HOLD_TICKS[`MS_CNT_W-1:0];
  localparam [`MS_CNT_W-1:0] HWAKE_TIME = HWAKE_TICKS[`MS_CNT_W-1:0];
  localparam [`MS_CNT_W-1:0] LAMP_LAST  = LAMP_LAST_TICKS[`MS_CNT_W-1:0];
  localparam [`MS_CNT_W-1:0] STEP       = STEP_TICKS[`MS_CNT_W-1:0];
  localparam [`TICK_CNT_W-1:0] TICK_LAST = TICK_LAST_CYCLES[`TICK_CNT_W-1:0];

  // saturating increment shared by every millisecond counter
  function [`MS_CNT_W-1:0] sat_inc;
    input [`MS_CNT_W-1:0] value;
    begin
      if (&value)
        sat_inc = value;
      else
        sat_inc = value + {{(`MS_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // filtered pin levels
  wire key_level;
  wire reset_level;
  wire inhibit_level;

  input_filter #(
    .FILTER_LEN (`FILTER_CYCLES),
    .IDLE_LEVEL (1'b1)
  ) key_filter (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin_in (power_key_n),
    .level  (key_level)
  );

  input_filter #(
    .FILTER_LEN (`FILTER_CYCLES),
    .IDLE_LEVEL (1'b1)
  ) reset_filter (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin_in (hw_reset_n),
    .level  (reset_level)
  );

  // idle low matches the pin's pull-down, so sleep is permitted by default
  input_filter #(
    .FILTER_LEN (`FILTER_CYCLES),
    .IDLE_LEVEL (1'b0)
  ) inhibit_filter (
    .clock  (clock),
    .rst_n  (rst_n),
    .pin_in (sleep_inhibit),
    .level  (inhibit_level)
  );

  // millisecond tick
  reg [`TICK_CNT_W-1:0] tick_cnt;
  reg                   tick;

  always @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt <= {`TICK_CNT_W{1'b0}};
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= {`TICK_CNT_W{1'b0}};
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + {{(`TICK_CNT_W-1){1'b0}}, 1'b1};
      tick     <= 1'b0;
    end
  end

  // key hold measurement; fires once per press
  reg [`MS_CNT_W-1:0] key_ms;
  reg                 key_fired;
  reg [1:0]           state;
  wire [`MS_CNT_W-1:0] key_need = (state == `PWR_OFF) ? ON_HOLD : OFF_HOLD;
  wire key_event = !key_level && !key_fired && tick &&
                   (sat_inc(key_ms) >= key_need);

  always @(posedge clock) begin
    if (!rst_n) begin
      key_ms    <= {`MS_CNT_W{1'b0}};
      key_fired <= 1'b0;
    end else if (key_level) begin
      // a short press simply clears the count
      key_ms    <= {`MS_CNT_W{1'b0}};
      key_fired <= 1'b0;
    end else begin
      if (tick)
        key_ms <= sat_inc(key_ms);
      if (key_event)
        key_fired <= 1'b1;
    end
  end

  // hardware reset low time
  reg [`MS_CNT_W-1:0] rst_ms;
  reg                 reset_prev;
  wire reset_release = reset_level && !reset_prev;
  wire reset_too_long = !reset_level && (rst_ms >= RESET_MAX);

  always @(posedge clock) begin
    if (!rst_n) begin
      rst_ms     <= {`MS_CNT_W{1'b0}};
      reset_prev <= 1'b1;
    end else begin
      reset_prev <= reset_level;
      if (reset_level)
        rst_ms <= {`MS_CNT_W{1'b0}};
      else if (tick)
        rst_ms <= sat_inc(rst_ms);
    end
  end

  // power state machine
  reg [1:0]           next_state;
  reg [`MS_CNT_W-1:0] pwr_ms;
  reg                 reset_cut;

  always @* begin
    next_state = state;
    case (state)
      `PWR_OFF: begin
        if (key_event)
          next_state = `PWR_BOOT;
      end
      `PWR_BOOT: begin
        if (reset_too_long)
          next_state = `PWR_OFF;
        else if (key_event)
          next_state = `PWR_HALT;
        else if (reset_level && pwr_ms >= BOOT_TIME)
          next_state = `PWR_RUN;
      end
      `PWR_RUN: begin
        if (reset_too_long)
          next_state = `PWR_OFF;
        else if (reset_release && !reset_cut)
          next_state = `PWR_BOOT;
        else if (key_event)
          next_state = `PWR_HALT;
      end
      `PWR_HALT: begin
        if (pwr_ms >= HALT_TIME)
          next_state = `PWR_OFF;
      end
      default: next_state = `PWR_OFF;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      state          <= `PWR_OFF;
      pwr_ms         <= {`MS_CNT_W{1'b0}};
      reset_cut      <= 1'b0;
      power_on       <= 1'b0;
      core_reset     <= 1'b1;
      usb_dplus      <= 1'b0;
      startup_report <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state)
        pwr_ms <= {`MS_CNT_W{1'b0}};
      else if (tick)
        pwr_ms <= sat_inc(pwr_ms);
      // a reset that ran past the limit must not reboot on release
      if (reset_too_long)
        reset_cut <= 1'b1;
      else if (reset_level)
        reset_cut <= 1'b0;
      // boot restart after a reset release also goes through BOOT
      if (state == `PWR_BOOT && reset_release && !reset_cut)
        pwr_ms <= {`MS_CNT_W{1'b0}};
      power_on   <= (next_state != `PWR_OFF);
      core_reset <= (next_state == `PWR_OFF) || !reset_level;
      usb_dplus  <= (next_state == `PWR_RUN) && reset_level;
      startup_report <= (state == `PWR_BOOT) &&
                        (next_state == `PWR_RUN);
    end
  end

  // sleep control
  reg [`MS_CNT_W-1:0] wake_ms;
  wire running = (state == `PWR_RUN) && reset_level;

  always @(posedge clock) begin
    if (!rst_n) begin
      awake   <= 1'b0;
      wake_ms <= {`MS_CNT_W{1'b0}};
    end else begin
      if (!inhibit_level)
        wake_ms <= {`MS_CNT_W{1'b0}};
      else if (tick)
        wake_ms <= sat_inc(wake_ms);
      if (state == `PWR_OFF) begin
        awake <= 1'b0;
      end else if (!running) begin
        awake <= 1'b1;
      end else if (awake) begin
        if (sleep_request && !inhibit_level)
          awake <= 1'b0;
      end else if (wake_ms >= WAKE_HOLD) begin
        awake <= 1'b1;
      end
    end
  end

  // host wake pulse; a request during a pulse is absorbed by it
  reg [`MS_CNT_W-1:0] hwake_ms;

  always @(posedge clock) begin
    if (!rst_n) begin
      host_wake_out <= 1'b0;
      hwake_ms      <= {`MS_CNT_W{1'b0}};
    end else if (!running) begin
      host_wake_out <= 1'b0;
      hwake_ms      <= {`MS_CNT_W{1'b0}};
    end else if (host_wake_out) begin
      if (tick)
        hwake_ms <= sat_inc(hwake_ms);
      if (tick && sat_inc(hwake_ms) >= HWAKE_TIME)
        host_wake_out <= 1'b0;
    end else if (host_wake_request) begin
      host_wake_out <= 1'b1;
      hwake_ms      <= {`MS_CNT_W{1'b0}};
    end
  end

  // status lamp; high is dark since the pin sinks current
  reg [`MS_CNT_W-1:0] lamp_ms;
  reg                 next_lamp;

  always @* begin
    case (net_status)
      `NET_NO_SERVICE:
        next_lamp = !(lamp_ms < STEP ||
                      (lamp_ms >= 2 * STEP && lamp_ms < 3 * STEP));
      `NET_REGISTERED:
        next_lamp = !(lamp_ms < STEP);
      `NET_DIALUP:
        next_lamp = 1'b0;
      default:
        next_lamp = 1'b1;
    endcase
    if (state == `PWR_OFF)
      next_lamp = 1'b1;
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      lamp_ms         <= {`MS_CNT_W{1'b0}};
      status_lamp_out <= 1'b1;
    end else begin
      if (state == `PWR_OFF)
        lamp_ms <= {`MS_CNT_W{1'b0}};
      else if (tick)
        lamp_ms <= (lamp_ms >= LAMP_LAST) ? {`MS_CNT_W{1'b0}}
                                          : sat_inc(lamp_ms);
      status_lamp_out <= next_lamp;
    end
  end

endmodule // module_power_sleep_control
`default_nettype wire

/* power_ctl_checker.sv */
// Purpose: port assertions for module_power_sleep_control
// Assumes: one clock, synchronous active-low reset
// Notes:   hold and pulse widths are counted in helper logic
`timescale 1ns/10ps
`default_nettype none
module power_ctl_checker #(parameter TICK_CYCLES = 4) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // inputs
  input wire logic       power_key_n,
  input wire logic       sleep_inhibit,
  input wire logic       host_wake_request,
  input wire logic [1:0] net_status,
  // outputs
  input wire logic       power_on,
  input wire logic       core_reset,
  input wire logic       usb_dplus,
  input wire logic       startup_report,
  input wire logic       awake,
  input wire logic       host_wake_out,
  input wire logic       status_lamp_out
);
  int kcnt;
  int wcnt;
  int icnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // no saturation: runs are far shorter than the counter range
  always @(posedge clock) begin
    kcnt <= power_key_n ? 0 : kcnt + 1;
    wcnt <= host_wake_out ? wcnt + 1 : 0;
    icnt <= sleep_inhibit ? icnt + 1 : 0;
  end
  chk_on_after_hold: assert property
    ($rose(power_on) |-> kcnt >= 1000 * TICK_CYCLES)
    else $error("power came on before the key hold time");
  chk_dplus_needs_on: assert property
    (usb_dplus |-> power_on && !core_reset)
    else $error("D+ high while off or in reset");
  chk_report_pulse: assert property
    (startup_report |=> !startup_report && usb_dplus)
    else $error("startup report not a pulse at boot end");
  chk_sleep_blocked: assert property
    (power_on && icnt >= 24 |-> !$fell(awake))
    else $error("slept while inhibit held high");
  chk_wake_width: assert property
    ($fell(host_wake_out) |-> wcnt >= 999 * TICK_CYCLES
     && wcnt <= 1000 * TICK_CYCLES + 1)
    else $error("host wake pulse width wrong");
  chk_wake_cause: assert property
    ($rose(host_wake_out) |-> $past(host_wake_request) && power_on)
    else $error("host wake without request");
  chk_dark_off: assert property
    (!power_on && !$past(power_on) |-> status_lamp_out && !awake)
    else $error("lamp lit or awake while off");
  chk_dialup_lit: assert property
    (power_on && $past(power_on) && $past(net_status) == 2'h2
     |-> !status_lamp_out)
    else $error("lamp not steady low when connected");
  cover property ($rose(usb_dplus));
  cover property (power_on && $fell(awake));
  cover property ($fell(host_wake_out));
endmodule // power_ctl_checker
bind module_power_sleep_control power_ctl_checker
  #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (.clock(clock), .rst_n(rst_n),
  .power_key_n(power_key_n), .sleep_inhibit(sleep_inhibit),
  .host_wake_request(host_wake_request), .net_status(net_status),
  .power_on(power_on), .core_reset(core_reset), .usb_dplus(usb_dplus),
  .startup_report(startup_report), .awake(awake),
  .host_wake_out(host_wake_out), .status_lamp_out(status_lamp_out));
`default_nettype wire

/* dte_model.sv */
// Purpose: host side of the control pins
// Assumes: pins change just after a rising clock edge
// Notes:   idle levels match the pull directions of the pins
`timescale 1ns/10ps
`default_nettype none
module dte_model (
  // clock
  input  wire logic clock,
  // pins toward the module
  output var  logic power_key_n,
  output var  logic hw_reset_n,
  output var  logic sleep_inhibit
);
  initial begin
    power_key_n = 1'b1;
    hw_reset_n = 1'b1;
    sleep_inhibit = 1'b0;
  end
  task automatic hold_key(input int n);
    @(posedge clock);
    power_key_n <= 1'b0;
    repeat (n) @(posedge clock);
    power_key_n <= 1'b1;
  endtask
  task automatic hold_reset(input int n);
    @(posedge clock);
    hw_reset_n <= 1'b0;
    repeat (n) @(posedge clock);
    hw_reset_n <= 1'b1;
  endtask
  task automatic hold_inhibit(input int n);
    @(posedge clock);
    sleep_inhibit <= 1'b1;
    repeat (n) @(posedge clock);
    sleep_inhibit <= 1'b0;
  endtask
endmodule // dte_model
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for module_power_sleep_control
// Assumes: tick cut to 2 clocks, so one second is 2000 cycles
// Notes:   expectations are queued and compared by a watcher
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int TK   = 2;
  localparam int ON   = 1000 * TK;
  localparam int BOOT = 7000 * TK;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       sleep_request = 1'b0;
  logic       host_wake_request = 1'b0;
  logic [1:0] net_status = 2'h0;
  logic       meas = 1'b0;
  logic [3:0] e;
  logic [3:0] exp_q[$];
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         cnt;
  int         lows[4] = '{200 * TK, 100 * TK, 2000 * TK, 0};
  wire logic  power_key_n, hw_reset_n, sleep_inhibit;
  wire logic  power_on, core_reset, usb_dplus, startup_report;
  wire logic  awake, host_wake_out, status_lamp_out;
  wire logic [7:0] obs;
  assign obs = {status_lamp_out, host_wake_out, awake, startup_report,
                usb_dplus, core_reset, power_on, meas};
  always #10 clock = ~clock;
  dte_model dte_model_inst (.clock(clock), .power_key_n(power_key_n),
    .hw_reset_n(hw_reset_n), .sleep_inhibit(sleep_inhibit));
  module_power_sleep_control #(.TICK_CYCLES(TK))
    module_power_sleep_control_inst (.clock(clock), .rst_n(rst_n),
    .power_key_n(power_key_n), .hw_reset_n(hw_reset_n),
    .sleep_inhibit(sleep_inhibit), .sleep_request(sleep_request),
    .host_wake_request(host_wake_request), .net_status(net_status),
    .power_on(power_on), .core_reset(core_reset), .usb_dplus(usb_dplus),
    .startup_report(startup_report), .awake(awake),
    .host_wake_out(host_wake_out), .status_lamp_out(status_lamp_out));
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic seen, input logic want);
    checks_done++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %b want %b", $time, seen, want);
    end
  endtask
  // expect_bit waits an edge so the value under test has settled
  task automatic expect_bit(input int idx, input logic v);
    @(posedge clock);
    exp_q.push_back({idx[2:0], v});
  endtask
  always @(negedge clock)
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(obs[e[3:1]], e[0]);
    end
  task automatic wait_for(input int idx, input logic v, input int lim);
    cnt = 0;
    while (obs[idx] !== v) begin
      @(negedge clock);
      cnt++;
      if (cnt > lim) begin
        n_mismatch++;
        results();
      end
    end
  endtask
  task automatic lamp(input int s);
    @(posedge clock);
    net_status <= s[1:0];
    repeat (4) @(posedge clock);
    cnt = 0;
    repeat (2000 * TK) begin
      @(negedge clock);
      cnt += (status_lamp_out === 1'b0);
    end
    meas = (cnt == lows[s]);
  endtask
  task automatic note(input string t);
    $display("test %s finished", t);
  endtask
  initial begin
    void'($urandom(66));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    expect_bit(1, 1'b0);
    expect_bit(5, 1'b0);
    note("reset");
    dte_model_inst.hold_key(100 + $urandom % (ON - 300));
    repeat (60) @(posedge clock);
    expect_bit(1, 1'b0);
    note("short press");
    dte_model_inst.hold_key(ON + 100);
    expect_bit(1, 1'b1);
    wait_for(3, 1'b1, BOOT + 500);
    check(startup_report, 1'b1);
    meas = (cnt >= BOOT - 200 && cnt <= BOOT + 10);
    expect_bit(0, 1'b1);
    expect_bit(5, 1'b1);
    note("power on");
    for (int s = 0; s < 4; s++) begin
      lamp(s);
      expect_bit(0, 1'b1);
    end
    note("lamp");
    fork
      dte_model_inst.hold_inhibit(600);
      begin
        repeat (100) @(posedge clock);
        sleep_request <= 1'b1;
        repeat (100) @(posedge clock);
        expect_bit(5, 1'b1);
      end
    join
    repeat (60) @(posedge clock);
    expect_bit(5, 1'b0);
    sleep_request <= 1'b0;
    fork
      dte_model_inst.hold_inhibit(ON + 100);
      begin
        repeat (ON / 2) @(posedge clock);
        expect_bit(5, 1'b0);
      end
    join
    expect_bit(5, 1'b1);
    note("sleep");
    @(posedge clock);
    host_wake_request <= 1'b1;
    @(posedge clock);
    host_wake_request <= 1'b0;
    expect_bit(6, 1'b1);
    repeat (ON / 2) @(posedge clock);
    host_wake_request <= 1'b1;
    @(posedge clock);
    host_wake_request <= 1'b0;
    wait_for(6, 1'b0, ON);
    meas = (cnt >= ON / 2 - 20 && cnt <= ON / 2 + 5);
    expect_bit(0, 1'b1);
    note("host wake");
    dte_model_inst.hold_reset(8);
    repeat (30) @(posedge clock);
    expect_bit(2, 1'b0);
    fork
      dte_model_inst.hold_reset(100);
      begin
        repeat (60) @(posedge clock);
        expect_bit(2, 1'b1);
        expect_bit(3, 1'b0);
      end
    join
    wait_for(3, 1'b1, BOOT + 500);
    check(startup_report, 1'b1);
    expect_bit(1, 1'b1);
    note("reset pulse");
    fork
      dte_model_inst.hold_key(4 * ON + 100);
      begin
        wait_for(3, 1'b0, 4 * ON + 200);
        meas = (cnt >= 4 * ON);
        expect_bit(0, 1'b1);
      end
    join
    wait_for(1, 1'b0, 4 * ON + 200);
    expect_bit(1, 1'b0);
    note("power off");
    dte_model_inst.hold_key(ON + 100);
    expect_bit(1, 1'b1);
    dte_model_inst.hold_reset(ON + 100);
    expect_bit(1, 1'b0);
    repeat (200) @(posedge clock);
    expect_bit(1, 1'b0);
    note("long reset");
    results();
  end
endmodule // tb_top
`default_nettype wire
